/* File: verilog/tso_switch.sv */
// Four-channel threshold switching logic with calibration and Wishbone registers
`timescale 1ns/100ps

// Functional notes
// - Switching states leave on the report stream to Ethernet, not on pins.
// - Teach command loads channel switching point with current distance.
// - High polarity asserts below the point; low polarity asserts above it.
// - Manual switching point is entered in tenths of a millimetre.
// - Single-point mode asserts on undershoot (high) or overshoot (low).
// - Delay mode delays state changes or issues one short pulse.
// - Delay times are configured in milliseconds.
// - Background mode switches when taught background is hidden or moves.
// - Window mode asserts only while value lies between lower and upper; with low polarity the code asserts outside that window.
// - Edge mode asserts when sample difference is within min and max.
// - Edge direction selects both, increasing or decreasing; increasing default.
// - Cycle offset 0 to 100000 picks compared earlier sample; default 0.
// - Edge mode needs fixed cycle of 25 us; auto rate is replaced.
// - Upper and lower limits accept signed values within 2000 mm.
// - Hysteresis within 2000 mm, default zero, separates on and off points.
// - Switch-on delay 0 to 100 ms; shorter conditions never switch on.
// - Switch-off delay 0 to 4000 ms postpones switching off.
// - Shift offset corrects each distance value before evaluation and reporting.
// - Thickness uses span only; distance uses span and shift.
// - One-shot emits output once for the off delay, then turns off.
// - Four independent channels each hold a full settings set.
module tso_switch #(
  parameter int MS_CYCLES = tso_pkg::MS_CYC,
  parameter int EDGE_MIN_CYCLES = tso_pkg::EDGE_MIN_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Measurement stream
  input wire logic raw_valid,
  input wire logic signed [31:0] raw_distance,
  // Report toward Ethernet and sampling control
  output tso_pkg::tso_report_type report,
  output logic rate_auto_eff
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic signed [31:0] clamp_s(input logic signed [31:0] v);
    if (v > tso_pkg::LIM_UNITS) begin
      clamp_s = tso_pkg::LIM_UNITS;
    end else if (v < -tso_pkg::LIM_UNITS) begin
      clamp_s = -tso_pkg::LIM_UNITS;
    end else begin
      clamp_s = v;
    end
  endfunction

  function automatic logic [31:0] clamp_u(input logic [31:0] v, input logic [31:0] mx);
    clamp_u = (v > mx) ? mx : v;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    merge = (o & ~m) | (n & m);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  tso_pkg::tso_cfg_type cfg_r [tso_pkg::NCH];
  tso_pkg::tso_cfg_type cfg_nxt [tso_pkg::NCH];
  logic [1:0] ctrl_r, ctrl_nxt;
  logic [31:0] span_r, span_nxt;
  logic signed [31:0] shift_r, shift_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic [31:0] rd_c, wval;
  logic wr_stb, rd_stb, is_ch;
  logic [1:0] ach;
  logic signed [31:0] cal_r, cal_nxt;
  logic cal_vld_r, cal_vld_nxt;
  logic signed [63:0] prod;
  logic signed [31:0] hist_mem [2**tso_pkg::HIST_AW];
  logic signed [31:0] hist_q_r;
  logic [tso_pkg::HIST_AW-1:0] wp_r, wp_nxt, rd_addr;
  logic [2:0] seq_r, seq_nxt;
  logic [1:0] rd_ch, ev_ch;
  logic ev_on;
  logic [17:0] ms_cnt_r, ms_cnt_nxt;
  logic ms_tick;
  logic [12:0] gap_r, gap_nxt;
  logic cyc_err_r, cyc_err_nxt;
  logic any_edge;
  logic [tso_pkg::NCH-1:0] out_r;
  tso_pkg::tso_report_type rep_r, rep_nxt;

  // ----------------------------------------------------------------
  // Bus decode and read mux
  // ----------------------------------------------------------------
  assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r;
  assign rd_stb = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_r;
  assign is_ch = (wb_adr_i[7] == tso_pkg::CH_SPACE);
  assign ach = wb_adr_i[6:5];
  assign any_edge = (cfg_r[0].func == tso_pkg::FN_EDGE) | (cfg_r[1].func == tso_pkg::FN_EDGE) |
                    (cfg_r[2].func == tso_pkg::FN_EDGE) | (cfg_r[3].func == tso_pkg::FN_EDGE);
  assign rate_auto_eff = ctrl_r[tso_pkg::CTRL_AUTO_BIT] & ~any_edge;

  always_comb begin
    rd_c = 32'h0;
    if (is_ch) begin
      case (wb_adr_i[4:0])
        tso_pkg::CH_MODE: rd_c = {26'h0, cfg_r[ach].one_shot, cfg_r[ach].dir,
                                  cfg_r[ach].pol_high, cfg_r[ach].func};
        tso_pkg::CH_UPPER: rd_c = cfg_r[ach].upper;
        tso_pkg::CH_LOWER: rd_c = cfg_r[ach].lower;
        tso_pkg::CH_HYST: rd_c = cfg_r[ach].hyst;
        tso_pkg::CH_ON: rd_c = {20'h0, cfg_r[ach].on_ms};
        tso_pkg::CH_OFF: rd_c = {20'h0, cfg_r[ach].off_ms};
        tso_pkg::CH_CYC: rd_c = {15'h0, cfg_r[ach].cyc_off};
        default: rd_c = 32'h0;
      endcase
    end else begin
      case (wb_adr_i)
        tso_pkg::REG_CTRL: rd_c = {30'h0, ctrl_r};
        tso_pkg::REG_SPAN: rd_c = span_r;
        tso_pkg::REG_SHIFT: rd_c = shift_r;
        tso_pkg::REG_CALV: rd_c = cal_r;
        tso_pkg::REG_STAT: rd_c = {26'h0, cyc_err_r, rate_auto_eff, out_r};
        default: rd_c = 32'h0;
      endcase
    end
  end

  assign wval = merge(rd_c, wb_dat_i, wb_sel_i);

  always_comb begin
    ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
    rdat_nxt = rd_stb ? rd_c : 32'h0;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0;
    end else begin
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_comb begin
    cfg_nxt = cfg_r;
    ctrl_nxt = ctrl_r;
    span_nxt = span_r;
    shift_nxt = shift_r;
    cyc_err_nxt = cyc_err_r;
    if (wr_stb && is_ch) begin
      case (wb_adr_i[4:0])
        tso_pkg::CH_MODE: begin
          cfg_nxt[ach].func = tso_pkg::tso_func_type'(wval[1:0]);
          cfg_nxt[ach].pol_high = wval[tso_pkg::MODE_POL_BIT];
          cfg_nxt[ach].dir = tso_pkg::tso_dir_type'(wval[tso_pkg::MODE_DIR_LSB +: 2]);
          cfg_nxt[ach].one_shot = wval[tso_pkg::MODE_SHOT_BIT];
        end
        tso_pkg::CH_UPPER: cfg_nxt[ach].upper = clamp_s(wval);
        tso_pkg::CH_LOWER: cfg_nxt[ach].lower = clamp_s(wval);
        tso_pkg::CH_HYST: cfg_nxt[ach].hyst = clamp_s(wval);
        tso_pkg::CH_ON: cfg_nxt[ach].on_ms =
          12'(clamp_u(wval, tso_pkg::ON_MAX_MS));
        tso_pkg::CH_OFF: cfg_nxt[ach].off_ms =
          12'(clamp_u(wval, tso_pkg::OFF_MAX_MS));
        tso_pkg::CH_CYC: cfg_nxt[ach].cyc_off =
          17'(clamp_u(wval, tso_pkg::CYC_MAX));
        tso_pkg::CH_MANUAL: cfg_nxt[ach].upper =
          clamp_s(32'(signed'(wval) * tso_pkg::MANUAL_SCALE));
        default: ;
      endcase
    end else if (wr_stb) begin
      case (wb_adr_i)
        tso_pkg::REG_CTRL: ctrl_nxt = wval[1:0];
        tso_pkg::REG_SPAN: span_nxt = wval;
        tso_pkg::REG_SHIFT: shift_nxt = wval;
        tso_pkg::REG_STAT: if (wval[tso_pkg::STAT_CYCERR_BIT]) cyc_err_nxt = 1'b0;
        default: ;
      endcase
    end
    for (int i = 0; i < tso_pkg::NCH; i++) begin
      if (wr_stb && !is_ch && wb_adr_i == tso_pkg::REG_TEACH && wval[i]) begin
        cfg_nxt[i].upper = cal_r;
      end
    end
    // Set wins over a clear in the same cycle
    if (raw_valid && any_edge && gap_r < 13'(EDGE_MIN_CYCLES)) begin
      cyc_err_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < tso_pkg::NCH; i++) begin
        cfg_r[i] <= tso_pkg::CFG_RST;
      end
      ctrl_r <= tso_pkg::CTRL_RST;
      span_r <= tso_pkg::SPAN_RST;
      shift_r <= tso_pkg::SHIFT_RST;
      cyc_err_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      ctrl_r <= ctrl_nxt;
      span_r <= span_nxt;
      shift_r <= shift_nxt;
      cyc_err_r <= cyc_err_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Calibration, timing base and sample sequencer
  // ----------------------------------------------------------------
  assign prod = raw_distance * signed'(span_r);
  assign ms_tick = (ms_cnt_r == 18'(MS_CYCLES - 1));
  assign rd_ch = 2'(seq_r - 3'h1);
  assign ev_ch = 2'(seq_r - 3'h2);
  assign ev_on = (seq_r >= 3'h2) && (seq_r <= 3'h5);
  assign rd_addr = wp_r - 17'h1 - cfg_r[rd_ch].cyc_off;

  always_comb begin
    cal_vld_nxt = raw_valid;
    cal_nxt = cal_r;
    if (raw_valid) begin
      cal_nxt = prod[47:16];
      if (!ctrl_r[tso_pkg::CTRL_THICK_BIT]) begin
        cal_nxt = prod[47:16] + shift_r;
      end
    end
    ms_cnt_nxt = ms_tick ? 18'h0 : ms_cnt_r + 18'h1;
    gap_nxt = raw_valid ? 13'h0 : ((gap_r == 13'h1fff) ? gap_r : gap_r + 13'h1);
    seq_nxt = seq_r;
    wp_nxt = wp_r;
    if (seq_r == 3'h0) begin
      if (cal_vld_r) seq_nxt = 3'h1;
    end else begin
      seq_nxt = seq_r + 3'h1;
      if (seq_r == tso_pkg::SEQ_LAST) wp_nxt = wp_r + 17'h1;
    end
    rep_nxt = rep_r;
    rep_nxt.valid = (seq_r == tso_pkg::SEQ_LAST);
    if (seq_r == tso_pkg::SEQ_LAST) begin
      rep_nxt.cal = cal_r;
      rep_nxt.out_noninv = out_r;
      rep_nxt.out_inv = ~out_r;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cal_r <= 32'sh0;
      cal_vld_r <= 1'b0;
      ms_cnt_r <= 18'h0;
      gap_r <= 13'h1fff;
      seq_r <= 3'h0;
      wp_r <= 17'h0;
      rep_r <= '{1'b0, 32'sh0, 4'h0, 4'hf};
    end else begin
      cal_r <= cal_nxt;
      cal_vld_r <= cal_vld_nxt;
      ms_cnt_r <= ms_cnt_nxt;
      gap_r <= gap_nxt;
      seq_r <= seq_nxt;
      wp_r <= wp_nxt;
      rep_r <= rep_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (cal_vld_r && seq_r == 3'h0) begin
      hist_mem[wp_r] <= cal_r;
    end
    hist_q_r <= hist_mem[rd_addr];
  end

  assign report = rep_r;

  // ----------------------------------------------------------------
  // Per-channel evaluation and delay stage
  // ----------------------------------------------------------------
  for (genvar g = 0; g < tso_pkg::NCH; g++) begin : g_ch
    tso_pkg::tso_cfg_type c;
    logic cond_r, cond_nxt, in_prev, in_c;
    logic signed [32:0] v, up, lo, hy, diff, mag, dev;
    tso_pkg::tso_sw_state_type st_r, st_nxt;
    logic [11:0] tim_r, tim_nxt;
    logic out_nxt;

    assign c = cfg_r[g];
    assign v = 33'(cal_r);
    assign up = 33'(c.upper);
    assign lo = 33'(c.lower);
    assign hy = 33'(c.hyst);
    assign diff = v - 33'(hist_q_r);
    assign mag = diff[32] ? -diff : diff;
    assign dev = (v >= up) ? v - up : up - v;
    assign in_prev = cond_r ^ ~c.pol_high;

    always_comb begin
      in_c = 1'b0;
      cond_nxt = cond_r;
      case (c.func)
        tso_pkg::FN_WINDOW: in_c = in_prev ? (v > lo - hy && v < up + hy)
                                           : (v > lo && v < up);
        tso_pkg::FN_EDGE: in_c = (mag >= lo) && (mag <= up) &&
          ((c.dir == tso_pkg::DIR_BOTH) ||
           (c.dir == tso_pkg::DIR_POS && diff > 33'sh0) ||
           (c.dir == tso_pkg::DIR_NEG && diff < 33'sh0));
        tso_pkg::FN_BACK: in_c = in_prev ? (dev > lo - hy) : (dev > lo);
        default: in_c = 1'b0;
      endcase
      if (ev_on && ev_ch == 2'(g)) begin
        if (c.func == tso_pkg::FN_SINGLE) begin
          if (c.pol_high) begin
            cond_nxt = cond_r ? (v < up + hy) : (v < up);
          end else begin
            cond_nxt = cond_r ? (v > up - hy) : (v > up);
          end
        end else begin
          cond_nxt = in_c ^ ~c.pol_high;
        end
      end
    end

    always_comb begin
      st_nxt = st_r;
      tim_nxt = (ms_tick && tim_r != 12'h0) ? tim_r - 12'h1 : tim_r;
      case (st_r)
        tso_pkg::SW_OFF: if (cond_r) begin
          if (c.on_ms != 12'h0) begin
            st_nxt = tso_pkg::SW_ONW;
            tim_nxt = c.on_ms;
          end else begin
            st_nxt = c.one_shot ? tso_pkg::SW_HOLD : tso_pkg::SW_ON;
            tim_nxt = c.off_ms;
          end
        end
        tso_pkg::SW_ONW: if (!cond_r) begin
          st_nxt = tso_pkg::SW_OFF;
        end else if (tim_r == 12'h0) begin
          st_nxt = c.one_shot ? tso_pkg::SW_HOLD : tso_pkg::SW_ON;
          tim_nxt = c.off_ms;
        end
        tso_pkg::SW_ON: if (!cond_r) begin
          st_nxt = (c.off_ms != 12'h0) ? tso_pkg::SW_OFFW : tso_pkg::SW_OFF;
          tim_nxt = c.off_ms;
        end
        tso_pkg::SW_OFFW: if (cond_r) begin
          st_nxt = tso_pkg::SW_ON;
        end else if (tim_r == 12'h0) begin
          st_nxt = tso_pkg::SW_OFF;
        end
        tso_pkg::SW_HOLD: if (tim_r == 12'h0) begin
          st_nxt = tso_pkg::SW_SPENT;
        end
        tso_pkg::SW_SPENT: if (!cond_r) begin
          st_nxt = tso_pkg::SW_OFF;
        end
        default: st_nxt = tso_pkg::SW_OFF;
      endcase
      out_nxt = (st_nxt == tso_pkg::SW_ON) || (st_nxt == tso_pkg::SW_OFFW) ||
                (st_nxt == tso_pkg::SW_HOLD);
    end

    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        cond_r <= 1'b0;
        st_r <= tso_pkg::SW_OFF;
        tim_r <= 12'h0;
        out_r[g] <= 1'b0;
      end else begin
        cond_r <= cond_nxt;
        st_r <= st_nxt;
        tim_r <= tim_nxt;
        out_r[g] <= out_nxt;
      end
    end
  end

endmodule

/* File: include/tso_pkg.sv */
// Package: register map, field layout, reset values and types of the switching block
package tso_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NCH = 4;
  localparam int HIST_AW = 17;
  localparam logic [2:0] SEQ_LAST = 3'h7;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SPAN = 8'h04;
  localparam logic [7:0] REG_SHIFT = 8'h08;
  localparam logic [7:0] REG_CALV = 8'h0c;
  localparam logic [7:0] REG_STAT = 8'h10;
  localparam logic [7:0] REG_TEACH = 8'h14;
  localparam logic CH_SPACE = 1'h1;
  localparam logic [4:0] CH_MODE = 5'h00;
  localparam logic [4:0] CH_UPPER = 5'h04;
  localparam logic [4:0] CH_LOWER = 5'h08;
  localparam logic [4:0] CH_HYST = 5'h0c;
  localparam logic [4:0] CH_ON = 5'h10;
  localparam logic [4:0] CH_OFF = 5'h14;
  localparam logic [4:0] CH_CYC = 5'h18;
  localparam logic [4:0] CH_MANUAL = 5'h1c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_THICK_BIT = 0;
  localparam int CTRL_AUTO_BIT = 1;
  localparam int STAT_AUTO_BIT = 4;
  localparam int STAT_CYCERR_BIT = 5;
  localparam int MODE_POL_BIT = 2;
  localparam int MODE_DIR_LSB = 3;
  localparam int MODE_SHOT_BIT = 5;

  // ----------------------------------------------------------------
  // Units, limits and reset values
  // ----------------------------------------------------------------
  localparam logic signed [31:0] UNITS_PER_MM = 32'sh0000_2710;
  localparam logic signed [31:0] LIM_MM = 32'sh0000_07d0;
  localparam logic signed [31:0] LIM_UNITS = LIM_MM * UNITS_PER_MM;
  localparam logic signed [31:0] MANUAL_SCALE = 32'sh0000_03e8;
  localparam logic [31:0] ON_MAX_MS = 32'h0000_0064;
  localparam logic [31:0] OFF_MAX_MS = 32'h0000_0fa0;
  localparam logic [31:0] CYC_MAX = 32'h0001_86a0;
  localparam logic [31:0] SPAN_RST = 32'h0001_0000;
  localparam logic [31:0] SHIFT_RST = 32'h0000_0000;
  localparam logic [1:0] CTRL_RST = 2'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 200000;
  localparam int MS_UNIT = 1;
  localparam int MS_CYC = MS_UNIT * CLK_KHZ;
  localparam int EDGE_MIN_US = 25;
  localparam int EDGE_MIN_CYC = (EDGE_MIN_US * CLK_KHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FN_SINGLE = 2'h0, FN_WINDOW = 2'h1, FN_EDGE = 2'h2, FN_BACK = 2'h3
  } tso_func_type;

  typedef enum logic [1:0] {
    DIR_BOTH = 2'h0, DIR_POS = 2'h1, DIR_NEG = 2'h2
  } tso_dir_type;

  typedef enum logic [5:0] {
    SW_OFF = 6'h01, SW_ONW = 6'h02, SW_ON = 6'h04,
    SW_OFFW = 6'h08, SW_HOLD = 6'h10, SW_SPENT = 6'h20
  } tso_sw_state_type;

  typedef struct packed {
    tso_func_type func;
    logic pol_high;
    tso_dir_type dir;
    logic one_shot;
    logic signed [31:0] upper;
    logic signed [31:0] lower;
    logic signed [31:0] hyst;
    logic [11:0] on_ms;
    logic [11:0] off_ms;
    logic [16:0] cyc_off;
  } tso_cfg_type;

  localparam tso_cfg_type CFG_RST = '{FN_SINGLE, 1'h1, DIR_POS, 1'h0,
    32'sh0, 32'sh0, 32'sh0, 12'h0, 12'h0, 17'h0};

  typedef struct packed {
    logic valid;
    logic signed [31:0] cal;
    logic [NCH-1:0] out_noninv;
    logic [NCH-1:0] out_inv;
  } tso_report_type;

endpackage

/* File: testbench/tso_monitor.sv */
// Port checks for the switching block
`timescale 1ns/100ps
module tso_monitor #(
  parameter int MS_CYCLES = 20,
  parameter int EDGE_MIN_CYCLES = 50
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Sample stream
  input wire logic raw_valid,
  input wire tso_pkg::tso_report_type report
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_out_inverse: assert property (report.out_inv == ~report.out_noninv)
    else $error("inverted outputs wrong");
  a_report_delay: assert property (report.valid |-> $past(raw_valid, 9))
    else $error("report without sample");
  a_valid_pulse: assert property (report.valid |=> !report.valid)
    else $error("report valid too long");
  a_report_hold: assert property (!report.valid |-> $stable(report.out_noninv) && $stable(report.cal))
    else $error("report changed between samples");
endmodule

bind tso_switch tso_monitor #(.MS_CYCLES(MS_CYCLES), .EDGE_MIN_CYCLES(EDGE_MIN_CYCLES)) u_mon (
  .clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .raw_valid(raw_valid), .report(report));

/* File: testbench/tso_host_model.sv */
// Host side model collecting switching reports
`timescale 1ns/100ps
module tso_host_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Report stream
  input wire tso_pkg::tso_report_type report,
  // Captured view
  output int n_rx,
  output logic [3:0] rx_outs,
  output logic signed [31:0] rx_cal
);
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      n_rx <= 0;
      rx_outs <= 4'h0;
      rx_cal <= 32'sh0;
    end else if (report.valid) begin
      n_rx <= n_rx + 1;
      rx_outs <= report.out_noninv;
      rx_cal <= report.cal;
    end
  end
endmodule

/* File: testbench/test_threshold_switching_output.sv */
// Self-checking bench of the switching block
`timescale 1ns/100ps
module test_threshold_switching_output;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic raw_valid = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, dat_o;
  logic ack, rate_eff;
  logic signed [31:0] raw = 32'sh0;
  tso_pkg::tso_report_type rep;
  int n_fail = 0;
  int samples_checked = 0;
  int n_sent = 0;
  int n_rx, seed;
  logic [3:0] rx_outs;
  logic signed [31:0] rx_cal;
  longint span = 65536, shift = 0, cal_m = 0;
  bit thick = 0;
  longint pt[4] = '{0, 0, 0, 0};
  longint lo[4] = '{0, 0, 0, 0};
  bit pol[4] = '{1, 1, 1, 1};
  int fn[4] = '{0, 0, 0, 0};
  longint hy[4] = '{0, 0, 0, 0};
  logic [3:0] hit_m = 4'h0, outs_m = 4'h0, shot = 4'h0;
  logic [4:0] offs[6] = '{5'h10, 5'h14, 5'h18, 5'h04, 5'h08, 5'h0c};
  logic [31:0] vals[6] = '{32'd200, 32'd5000, 32'd200000, 32'h7fff_ffff, 32'h8000_0001, 32'h7fff_ffff};

  always #2.5 clk = ~clk;

  tso_switch #(.MS_CYCLES(20), .EDGE_MIN_CYCLES(50)) DUT (
    .clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .raw_valid(raw_valid),
    .raw_distance(raw), .report(rep), .rate_auto_eff(rate_eff));
  tso_host_model u_host (.clk(clk), .rst_b(rst_b), .report(rep), .n_rx(n_rx),
    .rx_outs(rx_outs), .rx_cal(rx_cal));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task finish_test;
    $display("checked %0d, failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  function automatic logic [7:0] ch(input int n, input logic [4:0] off);
    return 8'h80 + 8'(n * 32) + {3'h0, off};
  endfunction

  function automatic logic [3:0] exp_outs(input longint c);
    logic [3:0] o;
    bit hit;
    longint h;
    for (int i = 0; i < 4; i++) begin
      h = hit_m[i] ? hy[i] : 0;
      hit = (fn[i] == 1) ? (c > lo[i] && c < pt[i]) :
        (pol[i] ? c < pt[i] + h : c > pt[i] - h);
      o[i] = (fn[i] == 1 && !pol[i]) ? !hit : hit;
    end
    return o;
  endfunction

  task sample(input longint r);
    logic [3:0] cnd;
    @(posedge clk);
    raw_valid <= 1'b1;
    raw <= r[31:0];
    @(posedge clk);
    raw_valid <= 1'b0;
    while (rep.valid !== 1'b1) @(posedge clk);
    cal_m = ((r * span) >>> 16) + (thick ? 0 : shift);
    cnd = exp_outs(cal_m);
    outs_m = cnd & ~(shot & hit_m);
    hit_m = cnd;
    chk(rep.cal, cal_m[31:0]);
    chk({28'h0, rep.out_noninv}, {28'h0, outs_m});
    n_sent++;
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    seed = $urandom(32'h7bb8);
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    bus(0, tso_pkg::REG_SPAN, 0);
    chk(rdat, tso_pkg::SPAN_RST);
    bus(0, ch(0, tso_pkg::CH_MODE), 0);
    chk(rdat, 32'h0000_000c);
    bus(0, ch(1, tso_pkg::CH_HYST), 0);
    chk(rdat, 32'h0);
    bus(1, 8'h20, 32'h1234_5678);
    bus(0, 8'h20, 0);
    chk(rdat, 32'h0);
    $display("reset values done");
    for (int i = 0; i < 6; i++) begin
      bus(1, ch(1, offs[i]), vals[i]);
      bus(0, ch(1, offs[i]), 0);
      chk(rdat, i == 0 ? tso_pkg::ON_MAX_MS : i == 1 ? tso_pkg::OFF_MAX_MS : i == 2 ?
        tso_pkg::CYC_MAX : i == 4 ? -tso_pkg::LIM_UNITS : tso_pkg::LIM_UNITS);
      bus(1, ch(1, offs[i]), 0);
    end
    $display("limits done");
    bus(1, tso_pkg::REG_SPAN, 32'h0002_0000);
    span = 131072;
    bus(1, tso_pkg::REG_SHIFT, 32'd100);
    shift = 100;
    bus(1, ch(0, tso_pkg::CH_UPPER), 32'd5000);
    pt[0] = 5000;
    bus(1, ch(1, tso_pkg::CH_MODE), 32'h08);
    pol[1] = 0;
    bus(1, ch(1, tso_pkg::CH_UPPER), 32'd5000);
    pt[1] = 5000;
    bus(1, ch(2, tso_pkg::CH_MODE), 32'h0d);
    fn[2] = 1;
    bus(1, ch(2, tso_pkg::CH_UPPER), 32'd11999);
    pt[2] = 11999;
    bus(1, ch(2, tso_pkg::CH_LOWER), 32'd4001);
    lo[2] = 4001;
    bus(1, ch(3, tso_pkg::CH_MANUAL), 32'd25);
    pt[3] = 25000;
    bus(0, ch(3, tso_pkg::CH_UPPER), 0);
    chk(rdat, 32'd25000);
    sample(2450);
    repeat (14) sample($urandom_range(0, 16000));
    $display("switching done");
    bus(1, tso_pkg::REG_CTRL, 32'h1);
    thick = 1;
    sample(3000);
    bus(1, tso_pkg::REG_CTRL, 32'h0);
    thick = 0;
    sample(4000);
    bus(1, tso_pkg::REG_TEACH, 32'h1);
    pt[0] = 8100;
    bus(0, ch(0, tso_pkg::CH_UPPER), 0);
    chk(rdat, 32'd8100);
    sample(4100);
    sample(3900);
    bus(0, tso_pkg::REG_CALV, 0);
    chk(rdat, cal_m[31:0]);
    $display("teach done");
    chk({28'h0, rx_outs}, {28'h0, outs_m});
    bus(1, ch(0, tso_pkg::CH_HYST), 32'd400);
    hy[0] = 400;
    sample(2100);
    bus(1, ch(1, tso_pkg::CH_OFF), 32'd2);
    bus(1, ch(1, tso_pkg::CH_MODE), 32'h28);
    shot[1] = 1'b1;
    sample(4050);
    repeat (60) @(posedge clk);
    sample(4250);
    sample(4050);
    $display("hysteresis and one-shot done");
    bus(1, tso_pkg::REG_CTRL, 32'h2);
    chk({31'h0, rate_eff}, 32'h1);
    bus(1, ch(3, tso_pkg::CH_MODE), 32'h0e);
    chk({31'h0, rate_eff}, 32'h0);
    chk(n_rx, n_sent);
    chk(rx_cal, cal_m[31:0]);
    chk({28'h0, rx_outs}, {28'h0, outs_m});
    $display("rate and host done");
    finish_test;
  end

  initial begin
    #300000;
    n_fail++;
    $display("Error at %0t: watchdog expired", $time);
    finish_test;
  end
endmodule
